// ==== logic/cioe_core.v ====
// Cyclic IO event flags, isochronous timing strobes and parameter record
// writer, with a plain strobe register port toward the host.
// Assumes new-data, record and frame inputs come from logic on core_clk;
// only cycle_sync_pin is asynchronous.
// The host is expected never to read and write in the same cycle.
`timescale 1ns/1ns
`include "cioe_defs.vh"
module cioe_core
#(
  parameter CW = 20
)
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire [15:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output wire        irq,
  input  wire        rx_new_data_rel0,
  input  wire        rx_new_data_rel1,
  input  wire        rec_start,
  input  wire        rec_byte_valid,
  input  wire [7:0]  rec_byte,
  input  wire        rec_end,
  output reg         rec_mem_we,
  output reg  [15:0] rec_mem_addr,
  output reg  [7:0]  rec_mem_wdata,
  input  wire        cycle_sync_pin,
  output reg         input_latch_pin,
  output reg         output_apply_pin,
  output reg         input_valid_pin,
  output reg         output_valid_pin,
  output reg         red_phase,
  input  wire        frame_req,
  input  wire        frame_is_rtc3,
  output wire        frame_grant
);
  // Record writer states, one-hot
  localparam [1:0] REC_IDLE = 2'b01;
  localparam [1:0] REC_RUN  = 2'b10;

  // Host visible registers
  reg  [31:0]   event_flags;
  reg  [31:0]   irq_mask;
  reg  [15:0]   init_param_length;
  reg  [15:0]   init_record_pointer;
  reg  [CW-1:0] latch_ofs;
  reg  [CW-1:0] apply_ofs;
  reg  [CW-1:0] red_len;
  reg  [CW-1:0] strobe_len;
  reg           iso_en;

  // Record writer state
  reg  [1:0]    rec_state;
  reg  [15:0]   rec_count;

  // Cycle bookkeeping and sync edge detection
  reg           rel0_seen;
  reg           sync_prev;

  // Per-cycle flag set and acknowledge clear vectors
  reg  [31:0]   ev_set;
  reg  [31:0]   ev_clr;

  // Sync and phase tracking
  wire          sync_level;
  wire          sync_edge;
  wire          cycle_start;
  wire [CW-1:0] phase;
  wire          locked;
  wire          sync_lost;

  // Windows, acknowledge decode and record writer strobes
  wire          win_latch;
  wire          win_apply;
  wire          win_red;
  wire          ack_wr;
  wire          rec_ovf;
  wire          rec_write;
  wire [31:0]   status_word;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // True while phase sits inside [start, start + len)
  function in_window;
    input [CW-1:0] ph;
    input [CW-1:0] start;
    input [CW-1:0] len;
    // Stop is one bit wider so start plus length cannot wrap
    reg   [CW:0]   stop;
    begin
      stop      = {1'b0, start} + {1'b0, len};
      in_window = ({1'b0, ph} >= {1'b0, start}) && ({1'b0, ph} < stop);
    end
  endfunction

  // Address match for a register write or read
  function hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Cycle sync input and phase tracking

  cioe_sync3 u_sync
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .pin_in    (cycle_sync_pin),
    .level_out (sync_level)
  );

  // Rising edge of the filtered sync marks a new isochronous cycle
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sync_prev <= 1'b0;
    else
      sync_prev <= sync_level;
  end

  // sync_prev resets low like the idle pin, so reset gives no false edge
  assign sync_edge = sync_level & ~sync_prev;

  // The tolerance in cycles bounds how far a sync may drift and keep lock
  cioe_cycle_pll
  #(
    .CW      (CW),
    .MAX_DEV (`CIOE_MAX_DEV_CYC)
  )
  u_pll
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .sync_edge   (sync_edge),
    .cycle_start (cycle_start),
    .phase       (phase),
    .locked      (locked),
    .sync_lost   (sync_lost)
  );

  //////////////////////////////////////////////////////////////////////////
  // Timing windows, all relative to the red phase start at phase zero

  // A window reaching past the cycle end is cut short by the next cycle start
  assign win_red   = iso_en & locked & in_window(phase, {CW{1'b0}}, red_len);
  assign win_latch = iso_en & locked & in_window(phase, latch_ofs, strobe_len);
  assign win_apply = iso_en & locked & in_window(phase, apply_ofs, strobe_len);

  // Registered pins; strobes are meant to feed host interrupt inputs directly
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      red_phase        <= 1'b0;
      input_latch_pin  <= 1'b0;
      output_apply_pin <= 1'b0;
      input_valid_pin  <= 1'b0;
      output_valid_pin <= 1'b0;
    end
    else
    begin
      red_phase        <= win_red;
      input_latch_pin  <= win_latch;
      output_apply_pin <= win_apply;
      input_valid_pin  <= iso_en & locked;
      output_valid_pin <= iso_en & locked & rel0_seen;
    end
  end

  // Fresh relation zero output data seen within the current cycle; a new
  // cycle forgets it, so output_valid_pin never vouches for stale data
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rel0_seen <= 1'b0;
    else if (cycle_start)
      rel0_seen <= rx_new_data_rel0;
    else if (rx_new_data_rel0)
      rel0_seen <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame forwarding gate; class 3 frames wait out the green phase so the
  // red phase stays deterministic
  assign frame_grant = frame_req & (red_phase ? frame_is_rtc3 : ~frame_is_rtc3);

  //////////////////////////////////////////////////////////////////////////
  // Parameter record writer

  // Bytes outside a transfer are ignored; a start is taken only in idle
  assign rec_write = (rec_state == REC_RUN) & rec_byte_valid;
  // The reserved space is the declared length; anything past it is dropped
  assign rec_ovf   = rec_write & (rec_count >= init_param_length);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rec_state     <= REC_IDLE;
      rec_count     <= 16'h0000;
      rec_mem_we    <= 1'b0;
      rec_mem_addr  <= 16'h0000;
      rec_mem_wdata <= 8'h00;
    end
    else
    begin
      rec_mem_we <= 1'b0;
      case (rec_state)
        REC_IDLE:
        begin
          if (rec_start)
          begin
            rec_count <= 16'h0000;
            rec_state <= REC_RUN;
          end
        end
        REC_RUN:
        begin
          if (rec_write && !rec_ovf)
          begin
            rec_mem_we    <= 1'b1;
            rec_mem_addr  <= init_record_pointer + rec_count;
            rec_mem_wdata <= rec_byte;
            rec_count     <= rec_count + 16'h0001;
          end
          // An end in the same cycle as a byte still stores that byte
          if (rec_end)
            rec_state <= REC_IDLE;
        end
        default:
          rec_state <= REC_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event flags: arrival pulses set, acknowledge ones clear, set wins

  assign ack_wr = reg_wr & hit(reg_addr, `CIOE_ADDR_ACK);

  always @*
  begin
    ev_set = 32'h00000000;
    // Only arrival pulses feed the new-data bits, never a buffer switch
    ev_set[`CIOE_EV_REL0]      = rx_new_data_rel0;
    ev_set[`CIOE_EV_REL1]      = rx_new_data_rel1;
    ev_set[`CIOE_EV_RED]       = win_red & ~red_phase;
    // Strobe flags mark the rising edge of each window, not its length
    ev_set[`CIOE_EV_LATCH]     = win_latch & ~input_latch_pin;
    ev_set[`CIOE_EV_APPLY]     = win_apply & ~output_apply_pin;
    ev_set[`CIOE_EV_REC_OVF]   = rec_ovf;
    ev_set[`CIOE_EV_SYNC_LOST] = sync_lost;
    ev_set[`CIOE_EV_REC_DONE]  = (rec_state == REC_RUN) & rec_end;
    // Zero bits of the acknowledge word leave their flag alone
    ev_clr = ack_wr ? (reg_wdata & `CIOE_EV_USED) : 32'h00000000;
  end

  // Flags are sticky; further arrivals never clear them
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      event_flags <= 32'h00000000;
    else
      event_flags <= ((event_flags & ~ev_clr) | ev_set) & `CIOE_EV_USED;
  end

  // Level interrupt, held while any unmasked flag stays set
  assign irq = |(event_flags & irq_mask);

  //////////////////////////////////////////////////////////////////////////
  // Writable registers

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_mask            <= `CIOE_RST_MASK;
      init_param_length   <= `CIOE_RST_PARAM_LEN;
      init_record_pointer <= `CIOE_RST_REC_PTR;
      latch_ofs           <= `CIOE_RST_LATCH_OFS;
      apply_ofs           <= `CIOE_RST_APPLY_OFS;
      red_len             <= `CIOE_RST_RED_LEN;
      strobe_len          <= `CIOE_RST_STROBE_LEN;
      iso_en              <= `CIOE_RST_CTRL;
    end
    else if (reg_wr)
    begin
      // Unmapped addresses and the read-only flags ignore writes
      if (hit(reg_addr, `CIOE_ADDR_MASK))
        irq_mask <= reg_wdata & `CIOE_EV_USED;
      // Host declares header plus payload bytes; the device trusts it
      if (hit(reg_addr, `CIOE_ADDR_PARAM_LEN))
        init_param_length <= reg_wdata[15:0];
      if (hit(reg_addr, `CIOE_ADDR_REC_PTR))
        init_record_pointer <= reg_wdata[15:0];
      if (hit(reg_addr, `CIOE_ADDR_LATCH_OFS))
        latch_ofs <= reg_wdata[CW-1:0];
      if (hit(reg_addr, `CIOE_ADDR_APPLY_OFS))
        apply_ofs <= reg_wdata[CW-1:0];
      if (hit(reg_addr, `CIOE_ADDR_RED_LEN))
        red_len <= reg_wdata[CW-1:0];
      if (hit(reg_addr, `CIOE_ADDR_STROBE_LEN))
        strobe_len <= reg_wdata[CW-1:0];
      if (hit(reg_addr, `CIOE_ADDR_CTRL))
        iso_en <= reg_wdata[`CIOE_CTRL_ISO_EN];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status word: lock in bit 0, the running phase above it
  assign status_word = {{(31-CW){1'b0}}, phase, locked};

  // Read data, valid only in the cycle after the read strobe;
  // unmapped and write-only addresses read as zero
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (!reg_rd)
      reg_rdata <= 32'h00000000;
    else
    begin
      case (reg_addr)
        `CIOE_ADDR_EVENT:      reg_rdata <= event_flags;
        `CIOE_ADDR_MASK:       reg_rdata <= irq_mask;
        `CIOE_ADDR_PARAM_LEN:  reg_rdata <= {16'h0000, init_param_length};
        `CIOE_ADDR_REC_PTR:    reg_rdata <= {16'h0000, init_record_pointer};
        `CIOE_ADDR_LATCH_OFS:  reg_rdata <= {{(32-CW){1'b0}}, latch_ofs};
        `CIOE_ADDR_APPLY_OFS:  reg_rdata <= {{(32-CW){1'b0}}, apply_ofs};
        `CIOE_ADDR_RED_LEN:    reg_rdata <= {{(32-CW){1'b0}}, red_len};
        `CIOE_ADDR_STROBE_LEN: reg_rdata <= {{(32-CW){1'b0}}, strobe_len};
        `CIOE_ADDR_CTRL:       reg_rdata <= {31'h00000000, iso_en};
        `CIOE_ADDR_STATUS:     reg_rdata <= status_word;
        default:               reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule // cioe_core

// ==== logic/cioe_cycle_pll.v ====
// Cycle phase tracker locked to the cycle sync edge.
// Assumes sync_edge is a one-cycle pulse already in the core clock domain.
`timescale 1ns/1ns
module cioe_cycle_pll
#(
  parameter CW      = 20,
  parameter MAX_DEV = 100
)
(
  input  wire          core_clk,
  input  wire          rst,
  input  wire          sync_edge,
  output reg           cycle_start,
  output reg  [CW-1:0] phase,
  output reg           locked,
  output reg           sync_lost
);
  localparam [CW:0] DEV = MAX_DEV;

  reg [CW-1:0] period;
  reg          have_period;
  reg [CW-1:0] gap;
  wire [CW:0]  measured = {1'b0, gap} + {{CW{1'b0}}, 1'b1};
  wire [CW:0]  timeout  = {1'b0, period} + DEV;

  function [CW:0] abs_diff;
    input [CW:0] a;
    input [CW:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Realign on every sync; a missing sync past the tolerance drops lock
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      phase       <= {CW{1'b0}};
      period      <= {CW{1'b0}};
      have_period <= 1'b0;
      gap         <= {CW{1'b0}};
      locked      <= 1'b0;
      sync_lost   <= 1'b0;
      cycle_start <= 1'b0;
    end
    else
    begin
      cycle_start <= 1'b0;
      sync_lost   <= 1'b0;
      if (sync_edge)
      begin
        phase       <= {CW{1'b0}};
        period      <= measured[CW-1:0];
        have_period <= 1'b1;
        cycle_start <= 1'b1;
        locked      <= have_period && (abs_diff(measured, {1'b0, period}) < DEV);
      end
      else if (have_period && ({1'b0, phase} == timeout))
      begin
        phase       <= {CW{1'b0}};
        cycle_start <= 1'b1;
        sync_lost   <= locked;
        locked      <= 1'b0;
      end
      else if (phase != {CW{1'b1}})
        phase <= phase + {{(CW-1){1'b0}}, 1'b1};
      // Count from the last real sync only: a flywheel restart of phase
      // would otherwise shorten the next measurement and block lock
      if (sync_edge)
        gap <= {CW{1'b0}};
      else if (gap != {CW{1'b1}})
        gap <= gap + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // cioe_cycle_pll

// ==== logic/cioe_defs.vh ====
// Constants of the cyclic IO sync and event block: register offsets,
// event bit positions, reset values and timing counts.
// Assumes a 100 MHz core clock and a 16-bit byte address register port.
`ifndef CIOE_DEFS_VH
`define CIOE_DEFS_VH

// Register byte offsets
`define CIOE_ADDR_ACK        16'h0020
`define CIOE_ADDR_EVENT      16'h003c
`define CIOE_ADDR_MASK       16'h0040
`define CIOE_ADDR_PARAM_LEN  16'h0044
`define CIOE_ADDR_REC_PTR    16'h0048
`define CIOE_ADDR_LATCH_OFS  16'h004c
`define CIOE_ADDR_APPLY_OFS  16'h0050
`define CIOE_ADDR_RED_LEN    16'h0054
`define CIOE_ADDR_STROBE_LEN 16'h0058
`define CIOE_ADDR_CTRL       16'h005c
`define CIOE_ADDR_STATUS     16'h0060

// Event bit positions, shared by event, mask and acknowledge registers
`define CIOE_EV_RED       0
`define CIOE_EV_LATCH     1
`define CIOE_EV_APPLY     2
`define CIOE_EV_REC_OVF   3
`define CIOE_EV_SYNC_LOST 4
`define CIOE_EV_REC_DONE  5
`define CIOE_EV_REL1      7
`define CIOE_EV_REL0      8
`define CIOE_EV_USED      32'h000001bf

// Control and status bit positions
`define CIOE_CTRL_ISO_EN  0
`define CIOE_STAT_LOCKED  0

// Reset values
`define CIOE_RST_MASK       32'h00000000
`define CIOE_RST_PARAM_LEN  16'h0000
`define CIOE_RST_REC_PTR    16'h0000
`define CIOE_RST_LATCH_OFS  20'h00000
`define CIOE_RST_APPLY_OFS  20'h00000
`define CIOE_RST_RED_LEN    20'h00000
`define CIOE_RST_STROBE_LEN 20'h00001
`define CIOE_RST_CTRL       1'b0

// Parameter record header size in bytes
`define CIOE_REC_HDR_LEN 16'h0006

// Timing: clock period and permitted cycle start deviation
`define CIOE_CLK_PERIOD_NS 10
`define CIOE_MAX_DEV_NS    1000
`define CIOE_MAX_DEV_CYC   (`CIOE_MAX_DEV_NS / `CIOE_CLK_PERIOD_NS)

`endif

// ==== logic/cioe_sync3.v ====
// Three-stage synchroniser for an input pin from outside the clock domain.
// The output level changes only once stages two and three agree.
`timescale 1ns/1ns
module cioe_sync3
(
  input  wire core_clk,
  input  wire rst,
  input  wire pin_in,
  output reg  level_out
);
  reg meta;
  reg stage2;
  reg stage3;

  //////////////////////////////////////////////////////////////////////////
  // First stage is read only by the second, never by any logic
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta      <= 1'b0;
      stage2    <= 1'b0;
      stage3    <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      meta   <= pin_in;
      stage2 <= meta;
      stage3 <= stage2;
      if (stage2 == stage3)
        level_out <= stage3;
    end
  end
endmodule // cioe_sync3

// ==== test/cioe_chk_asserts.sv ====
// Port checker for cioe_core, attached by the bind at the foot.
// Assumes one clock domain and the register map of the defs header.
`timescale 1ns/1ns
`include "cioe_defs.vh"
module cioe_chk
(
  input wire        core_clk,
  input wire        rst,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        irq,
  input wire        rx_new_data_rel0,
  input wire        rx_new_data_rel1,
  input wire        rec_byte_valid,
  input wire        rec_mem_we,
  input wire        input_latch_pin,
  input wire        red_phase,
  input wire        frame_req,
  input wire        frame_is_rtc3,
  input wire        frame_grant
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Decoded flag reads and acknowledge writes
  wire rd_ev = reg_rd && reg_addr == `CIOE_ADDR_EVENT;
  wire wr_ack = reg_wr && reg_addr == `CIOE_ADDR_ACK;
  property p_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  property p_gate;
    frame_grant == (frame_req && (red_phase == frame_is_rtc3));
  endproperty
  property p_rel0;
    rx_new_data_rel0 ##1 rd_ev |=> reg_rdata[8];
  endproperty
  property p_rel1;
    rx_new_data_rel1 ##1 rd_ev |=> reg_rdata[7];
  endproperty
  // A pulse in the ack cycle wins, so it is left out
  property p_ack;
    wr_ack && reg_wdata[8] && !rx_new_data_rel0 ##1 rd_ev |=> !reg_rdata[8];
  endproperty
  property p_hold;
    rd_ev ##1 (reg_rdata[8] && rd_ev) |=> reg_rdata[8];
  endproperty
  property p_ack0;
    rd_ev ##1 (reg_rdata[8] && wr_ack && !reg_wdata[8]) ##1 rd_ev |=> reg_rdata[8];
  endproperty
  property p_rec;
    rec_mem_we |-> $past(rec_byte_valid);
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  a_gate: assert property (p_gate) else $error("frame gate wrong");
  a_rel0: assert property (p_rel0) else $error("bit 8 not set");
  a_rel1: assert property (p_rel1) else $error("bit 7 not set");
  a_ack: assert property (p_ack) else $error("ack did not clear");
  a_hold: assert property (p_hold) else $error("flag fell alone");
  a_ack0: assert property (p_ack0) else $error("zero ack cleared");
  a_rec: assert property (p_rec) else $error("store without byte");
  c_irq: cover property ($rose(irq));
  c_latch: cover property ($rose(input_latch_pin));
  c_rec: cover property (rec_mem_we);
endmodule // cioe_chk
bind cioe_core cioe_chk u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .rx_new_data_rel0(rx_new_data_rel0), .rx_new_data_rel1(rx_new_data_rel1),
  .rec_byte_valid(rec_byte_valid), .rec_mem_we(rec_mem_we),
  .input_latch_pin(input_latch_pin), .red_phase(red_phase), .frame_req(frame_req),
  .frame_is_rtc3(frame_is_rtc3), .frame_grant(frame_grant));

// ==== test/cioe_core_bench.sv ====
// Self-checking bench for cioe_core with the host side model.
// Assumes 100 MHz core_clk and the register map of the defs header.
`timescale 1ns/1ns
`include "cioe_defs.vh"
module cioe_core_bench;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [15:0] reg_addr = 16'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0, reg_rd = 1'b0, rel0 = 1'b0, rel1 = 1'b0;
  reg         rec_start = 1'b0, rec_byte_valid = 1'b0, rec_end = 1'b0;
  reg  [7:0]  rec_byte = 8'h0;
  reg         frame_req = 1'b0, frame_is_rtc3 = 1'b0, sync_en = 1'b0;
  wire [31:0] reg_rdata;
  wire [15:0] rec_mem_addr;
  wire [7:0]  rec_mem_wdata, l_w, a_w;
  wire        irq, rec_mem_we, cycle_sync_pin, latch_pin, apply_pin;
  wire        input_valid_pin, output_valid_pin, red_phase, frame_grant;
  integer     n_fail = 0, cmp_count = 0, n_wr = 0, i;
  reg  [31:0] rd_val;
  reg  [23:0] wlog [0:7];
  cioe_core uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .rx_new_data_rel0(rel0), .rx_new_data_rel1(rel1), .rec_start(rec_start),
    .rec_byte_valid(rec_byte_valid), .rec_byte(rec_byte), .rec_end(rec_end),
    .rec_mem_we(rec_mem_we), .rec_mem_addr(rec_mem_addr), .rec_mem_wdata(rec_mem_wdata),
    .cycle_sync_pin(cycle_sync_pin), .input_latch_pin(latch_pin),
    .output_apply_pin(apply_pin), .input_valid_pin(input_valid_pin),
    .output_valid_pin(output_valid_pin), .red_phase(red_phase), .frame_req(frame_req),
    .frame_is_rtc3(frame_is_rtc3), .frame_grant(frame_grant));
  cioe_host_model host (.core_clk(core_clk), .rst(rst), .sync_en(sync_en),
    .input_latch_pin(latch_pin), .output_apply_pin(apply_pin),
    .cycle_sync_pin(cycle_sync_pin), .latch_width(l_w), .apply_width(a_w));
  ////////////////////////////////////////
  initial forever #5 core_clk = ~core_clk;
  // Record store log; past eight entries only the count grows
  always @(posedge core_clk)
  begin
    if (rec_mem_we === 1'b1)
    begin
      if (n_wr < 8)
        wlog[n_wr] <= {rec_mem_addr, rec_mem_wdata};
      n_wr <= n_wr + 1;
    end
  end
  task final_report;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // One bus slot per call; strobes held until the next call
  task drive(input w, input r, input [15:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
    end
  endtask
  task wr(input [15:0] a, input [31:0] d);
    begin
      drive(1'b1, 1'b0, a, d);
      drive(1'b0, 1'b0, a, d);
      #1;
    end
  endtask
  task rd(input [15:0] a);
    begin
      drive(1'b0, 1'b1, a, 32'h0);
      drive(1'b0, 1'b0, a, 32'h0);
      #1 rd_val = reg_rdata;
    end
  endtask
  task pulse(input k);
    begin
      @(posedge core_clk);
      rel0 <= !k;
      rel1 <= k;
      @(posedge core_clk);
      rel0 <= 1'b0;
      rel1 <= 1'b0;
    end
  endtask
  task gate;
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        @(posedge core_clk);
        frame_req <= 1'b1;
        frame_is_rtc3 <= i[0];
        #1 chk(frame_grant, red_phase == i[0]);
      end
      frame_req <= 1'b0;
    end
  endtask
  // Bounded wait on valid (0) or red phase (1); running out ends the run
  task wait_hi(input integer sel);
    integer n;
    begin
      n = 0;
      while ((sel == 0 ? input_valid_pin : red_phase) !== 1'b1 && n < 3000)
      begin
        @(posedge core_clk);
        n = n + 1;
      end
      if (n >= 3000)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t wait ran out", $time);
        final_report;
      end
      #1;
    end
  endtask
  initial
  begin
    #900000 n_fail = n_fail + 1;
    final_report;
  end
  ////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(`CIOE_ADDR_MASK);
    chk(rd_val, `CIOE_RST_MASK);
    rd(`CIOE_ADDR_STROBE_LEN);
    chk(rd_val, 32'h1);
    rd(`CIOE_ADDR_ACK);
    chk(rd_val, 32'h0);
    wr(16'h0070, 32'hffffffff);
    rd(16'h0070);
    chk(rd_val, 32'h0);
    rd(`CIOE_ADDR_EVENT);
    chk(rd_val, 32'h0);
    chk(irq, 1'b0);
    $display("test reset done");
    pulse(1'b0);
    rd(`CIOE_ADDR_EVENT);
    chk(rd_val, 32'h100);
    pulse(1'b1);
    rd(`CIOE_ADDR_EVENT);
    chk(rd_val, 32'h180);
    wr(`CIOE_ADDR_ACK, 32'h100);
    // Pulse and read back to back, so the flag is seen the cycle after
    @(posedge core_clk);
    rel0 <= 1'b1;
    drive(1'b0, 1'b1, `CIOE_ADDR_EVENT, 32'h0);
    rel0 <= 1'b0;
    drive(1'b0, 1'b1, `CIOE_ADDR_EVENT, 32'h0);
    drive(1'b1, 1'b0, `CIOE_ADDR_ACK, 32'h0);
    drive(1'b0, 1'b1, `CIOE_ADDR_EVENT, 32'h0);
    drive(1'b0, 1'b0, `CIOE_ADDR_EVENT, 32'h0);
    #1 chk(reg_rdata, 32'h180);
    wr(`CIOE_ADDR_MASK, 32'h100);
    chk(irq, 1'b1);
    // Acknowledge and read back to back
    drive(1'b1, 1'b0, `CIOE_ADDR_ACK, 32'h100);
    rd(`CIOE_ADDR_EVENT);
    chk(rd_val, 32'h080);
    chk(irq, 1'b0);
    wr(`CIOE_ADDR_ACK, 32'h080);
    $display("test events done");
    wr(`CIOE_ADDR_PARAM_LEN, `CIOE_REC_HDR_LEN + 16'h2);
    wr(`CIOE_ADDR_REC_PTR, 32'h0100);
    @(posedge core_clk);
    rec_start <= 1'b1;
    @(posedge core_clk);
    rec_start <= 1'b0;
    rec_byte_valid <= 1'b1;
    rec_byte <= 8'ha0;
    // Nine bytes against room for eight: the last one overflows
    repeat (8) @(posedge core_clk) rec_byte <= rec_byte + 8'h1;
    @(posedge core_clk);
    rec_byte_valid <= 1'b0;
    rec_end <= 1'b1;
    @(posedge core_clk);
    rec_end <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(n_wr, 8);
    for (i = 0; i < 8; i = i + 1)
      chk(wlog[i], {16'h0100 + i[15:0], 8'ha0 + i[7:0]});
    rd(`CIOE_ADDR_EVENT);
    chk(rd_val, 32'h028);
    wr(`CIOE_ADDR_ACK, 32'h028);
    $display("test records done");
    gate;
    wr(`CIOE_ADDR_LATCH_OFS, 32'd20);
    wr(`CIOE_ADDR_APPLY_OFS, 32'd100);
    wr(`CIOE_ADDR_RED_LEN, 32'd50);
    wr(`CIOE_ADDR_STROBE_LEN, 32'd4);
    wr(`CIOE_ADDR_MASK, 32'h1);
    wr(`CIOE_ADDR_CTRL, 32'h1);
    sync_en <= 1'b1;
    wait_hi(0);
    wait_hi(1);
    gate;
    chk(irq, 1'b1);
    pulse(1'b0);
    @(posedge core_clk);
    #1 chk(output_valid_pin, 1'b1);
    repeat (900) @(posedge core_clk);
    chk(output_valid_pin, 1'b0);
    chk(l_w, 8'd4);
    chk(a_w, 8'd4);
    rd(`CIOE_ADDR_EVENT);
    chk(rd_val & 32'h7, 32'h7);
    sync_en <= 1'b0;
    repeat (600) @(posedge core_clk);
    rd(`CIOE_ADDR_EVENT);
    chk(rd_val[4], 1'b1);
    chk(input_valid_pin, 1'b0);
    $display("test timing done");
    final_report;
  end
endmodule // cioe_core_bench

// ==== test/cioe_host_model.sv ====
// Host side model: cycle sync source and strobe interrupt monitor.
// Assumes strobes are registered levels on core_clk.
`timescale 1ns/1ns
module cioe_host_model
#(
  parameter PERIOD = 400
)
(
  input  wire       core_clk,
  input  wire       rst,
  input  wire       sync_en,
  input  wire       input_latch_pin,
  input  wire       output_apply_pin,
  output reg        cycle_sync_pin,
  output reg  [7:0] latch_width,
  output reg  [7:0] apply_width
);
  reg [15:0] tick;
  reg [7:0]  run_l;
  reg [7:0]  run_a;
  ////////////////////////////////////////
  // Sync pulse four cycles wide; the pin rests low while no cycle runs
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick <= 16'h0;
      cycle_sync_pin <= 1'b0;
    end
    else
    begin
      tick <= (tick == PERIOD - 1 || !sync_en) ? 16'h0 : tick + 16'h1;
      cycle_sync_pin <= sync_en && tick < 16'h4;
    end
  end
  // Each strobe acts as an interrupt; its width is kept for the bench
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      run_l <= 8'h0;
      run_a <= 8'h0;
      latch_width <= 8'h0;
      apply_width <= 8'h0;
    end
    else
    begin
      run_l <= input_latch_pin ? run_l + 8'h1 : 8'h0;
      run_a <= output_apply_pin ? run_a + 8'h1 : 8'h0;
      if (!input_latch_pin && run_l != 8'h0)
        latch_width <= run_l;
      if (!output_apply_pin && run_a != 8'h0)
        apply_width <= run_a;
    end
  end
endmodule // cioe_host_model
